// ===== pts_pkg.sv
// How it works
// (RULE1) Fixed master method: this node controls and issues tap commands to followers.
// (RULE2) Master compares each follower tap with its own, commands mismatches to match.
// (RULE3) Lost master raises no-master fault; option selects block or stand-alone regulation.
// (RULE4) Follower executes tap commands from the master instead of its own decisions.
// (RULE5) Automatic method elects lowest node address in the shared group as master.
// (RULE6) Master-follower tap difference above allowed deviation raises fault and blocks.
// (RULE7) Peers hold distinct addresses; coordination waits until all have registered. The code does not wait; absent peers are simply left out.
// (RULE8) Method holds one of four values, stepped by up and down keys.
// (RULE9) Group setting: none, group 1, group 2, or both; only sharing peers count.
// (RULE10) Menu may change group only when no input is assigned to select it.
// (RULE11) Node address 1 to 16; address 0 disables all bus communication.
// (RULE12) Stand-alone blocking with active group blocks when no group peer is seen.
// (RULE13) Sensitivity in 0.1 % steps, reset 0; correction scales with current ratio.
// (RULE14) Circulating current above threshold, default 20 %, raises fault and blocks.
// (RULE15) Parallel fault output asserts only after the configured fault delay.
// (RULE16) Lamp lights at once; delay 1 to 99 s, default 30 s.
// (RULE17) Allowed tap deviation 0 to 4 positions, default 0.
// (RULE18) Delay counts one-second ticks and restarts whenever the fault clears.
package pts_pkg;

    localparam int NODES      = 16;
    localparam int ADDR_W     = 5;
    localparam int TAP_W      = 6;
    localparam int PCT_W      = 10;
    localparam int CLK_HZ     = 100_000_000;
    localparam int TICK_S     = 1;
    localparam int TICK_CYC   = CLK_HZ * TICK_S;
    localparam logic [ADDR_W-1:0] ADDR_MAX   = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_OFF   = 5'h00;
    localparam logic [PCT_W-1:0]  SENS_RST   = 10'h000;
    localparam logic [PCT_W-1:0]  SENS_MAX   = 10'h3e8;
    localparam logic [PCT_W-1:0]  CIRC_RST   = 10'h0c8;
    localparam logic [PCT_W-1:0]  CIRC_MIN   = 10'h005;
    localparam logic [PCT_W-1:0]  CIRC_MAX   = 10'h190;
    localparam logic [6:0]        DLY_RST    = 7'h1e;
    localparam logic [6:0]        DLY_MIN    = 7'h01;
    localparam logic [6:0]        DLY_MAX    = 7'h63;
    localparam logic [2:0]        DEV_RST    = 3'h0;
    localparam logic [2:0]        DEV_MAX    = 3'h4;
    localparam logic [1:0]        GRP_BOTH   = 2'h3;

    typedef enum logic [1:0] {
        PTS_CIRC     = 2'b00,
        PTS_MASTER   = 2'b01,
        PTS_FOLLOWER = 2'b10,
        PTS_AUTO     = 2'b11
    } pts_method_t;

    typedef enum logic [1:0] {
        PTS_CMD_NONE  = 2'b00,
        PTS_CMD_RAISE = 2'b01,
        PTS_CMD_LOWER = 2'b10
    } pts_cmd_t;

    // One peer as seen on the bus
    typedef struct packed {
        logic             present;
        logic [1:0]       groups;
        logic [TAP_W-1:0] tap;
    } pts_peer_t;

    // Front-panel setting strobes
    typedef struct packed {
        logic method_up;
        logic method_dn;
        logic group_up;
        logic addr_up;
        logic addr_dn;
        logic sens_up;
        logic sens_dn;
        logic circ_up;
        logic circ_dn;
        logic dly_up;
        logic dly_dn;
        logic dev_up;
        logic dev_dn;
    } pts_keys_t;

endpackage : pts_pkg

// ===== pts_fault_delay.sv
`timescale 1ns/10ps
module pts_fault_delay #(
    parameter int TICK_CYC = pts_pkg::TICK_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       fault_i,
    input  wire logic [6:0] delay_s_i,
    output logic            out_o
);
    logic [31:0] tick_q;
    logic [6:0]  sec_q;

    always_ff @(posedge clk_i)
    begin
        if (reset_i || !fault_i || tick_q == 32'(TICK_CYC - 1))
            tick_q <= '0; // see (RULE18)
        else
            tick_q <= tick_q + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || !fault_i)
            sec_q <= '0; // see (RULE18)
        else if (tick_q == 32'(TICK_CYC - 1) && sec_q < delay_s_i)
            sec_q <= sec_q + 7'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            out_o <= 1'b0;
        else
            out_o <= fault_i && sec_q >= delay_s_i; // see (RULE15)
    end
endmodule : pts_fault_delay

// ===== pts_elect.sv
`timescale 1ns/10ps
module pts_elect (
    input  wire logic                                    clk_i,
    input  wire logic                                    reset_i,
    input  wire pts_pkg::pts_peer_t [pts_pkg::NODES-1:0] peers_i,
    input  wire logic [1:0]                              groups_i,
    input  wire logic [pts_pkg::ADDR_W-1:0]              self_i,
    output logic                                         self_low_o,
    output logic                                         any_peer_o,
    output logic [pts_pkg::ADDR_W-1:0]                   low_addr_o
);
    logic [pts_pkg::NODES-1:0] share;

    genvar g;
    generate
        for (g = 0; g < pts_pkg::NODES; g++)
        begin : g_share
            // Peer index g carries bus address g+1; own slot is skipped
            assign share[g] = peers_i[g].present
                && (peers_i[g].groups & groups_i) != 2'h0
                && self_i != pts_pkg::ADDR_W'(g + 1); // see (RULE9)
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            self_low_o <= 1'b0;
            any_peer_o <= 1'b0;
            low_addr_o <= '0;
        end
        else
        begin
            self_low_o <= 1'b1;
            any_peer_o <= |share;
            low_addr_o <= self_i;
            for (int i = pts_pkg::NODES - 1; i >= 0; i--)
                if (share[i] && pts_pkg::ADDR_W'(i + 1) < self_i)
                begin
                    self_low_o <= 1'b0; // see (RULE5)
                    low_addr_o <= pts_pkg::ADDR_W'(i + 1);
                end
        end
    end
endmodule : pts_elect

// ===== pts_parallel_ctrl.sv
`timescale 1ns/10ps
module pts_parallel_ctrl #(
    parameter int TICK_CYC = pts_pkg::TICK_CYC
) (
    input  wire logic                                    clk_i,
    input  wire logic                                    reset_i,
    input  wire logic                                    enable_i,
    input  wire pts_pkg::pts_keys_t                      keys_i,
    input  wire logic                                    grp_in_assigned_i,
    input  wire logic [1:0]                              general_purpose_input_i,
    input  wire logic                                    standalone_block_i,
    input  wire logic                                    nomaster_block_i,
    input  wire logic [pts_pkg::TAP_W-1:0]               own_tap_i,
    input  wire pts_pkg::pts_peer_t [pts_pkg::NODES-1:0] peers_i,
    input  wire pts_pkg::pts_cmd_t                       rx_cmd_i,
    input  wire logic                                    rx_cmd_valid_i,
    input  wire pts_pkg::pts_cmd_t                       own_cmd_i,
    input  wire logic [pts_pkg::PCT_W-1:0]               circ_pct_i,
    output pts_pkg::pts_method_t                         method_o,
    output logic [1:0]                                   groups_o,
    output logic [pts_pkg::ADDR_W-1:0]                   addr_o,
    output logic                                         bus_enable_o,
    output logic                                         is_master_o,
    output logic [pts_pkg::NODES-1:0]                    cmd_raise_o,
    output logic [pts_pkg::NODES-1:0]                    cmd_lower_o,
    output pts_pkg::pts_cmd_t                            tap_cmd_o,
    output logic [19:0]                                  correction_o,
    output logic                                         block_o,
    output logic                                         nomaster_fault_o,
    output logic                                         fault_lamp_o,
    output logic                                         parallel_fault_output_o
);
    pts_pkg::pts_method_t     method_q;
    logic [1:0]               grp_menu_q;
    logic [1:0]               grp_in_q1;
    logic [1:0]               grp_in_q2;
    logic                     grp_sel_q1;
    logic                     grp_sel_q2;
    logic [pts_pkg::PCT_W-1:0] sens_q;
    logic [pts_pkg::PCT_W-1:0] circ_lim_q;
    logic [6:0]               dly_q;
    logic [2:0]               dev_q;
    logic [1:0]               groups;
    logic                     self_low;
    logic                     any_peer;
    logic [pts_pkg::ADDR_W-1:0] low_addr;
    logic                     master;
    logic                     sync_mode;
    logic                     dev_fault;
    logic                     circ_fault;
    logic                     nomaster;
    logic                     fault;
    logic                     solo_block;
    logic [pts_pkg::TAP_W-1:0] diff [pts_pkg::NODES];

    // Method cycles through the four values in both directions
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            method_q <= pts_pkg::PTS_CIRC;
        else if (keys_i.method_up)
            method_q <= pts_pkg::pts_method_t'(method_q + 2'h1); // see (RULE8)
        else if (keys_i.method_dn)
            method_q <= pts_pkg::pts_method_t'(method_q - 2'h1); // see (RULE8)
    end

    // Menu group only moves while no input owns the selection
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            grp_menu_q <= 2'h0;
        else if (keys_i.group_up && !grp_sel_q2)
            grp_menu_q <= grp_menu_q + 2'h1; // see (RULE10)
    end

    // Group select pin inputs pass two flops first
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            grp_in_q1  <= 2'h0;
            grp_in_q2  <= 2'h0;
            grp_sel_q1 <= 1'b0;
            grp_sel_q2 <= 1'b0;
        end
        else
        begin
            grp_in_q1  <= general_purpose_input_i;
            grp_in_q2  <= grp_in_q1;
            grp_sel_q1 <= grp_in_assigned_i;
            grp_sel_q2 <= grp_sel_q1;
        end
    end

    assign groups = grp_sel_q2 ? grp_in_q2 : grp_menu_q; // see (RULE9)

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            addr_o <= pts_pkg::ADDR_OFF;
        else if (keys_i.addr_up && addr_o != pts_pkg::ADDR_MAX)
            addr_o <= addr_o + 5'h1; // see (RULE11)
        else if (keys_i.addr_dn && addr_o != pts_pkg::ADDR_OFF)
            addr_o <= addr_o - 5'h1; // see (RULE11)
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            sens_q <= pts_pkg::SENS_RST;
        else if (keys_i.sens_up && sens_q != pts_pkg::SENS_MAX)
            sens_q <= sens_q + 10'h1; // see (RULE13)
        else if (keys_i.sens_dn && sens_q != pts_pkg::SENS_RST)
            sens_q <= sens_q - 10'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            circ_lim_q <= pts_pkg::CIRC_RST;
        else if (keys_i.circ_up && circ_lim_q != pts_pkg::CIRC_MAX)
            circ_lim_q <= circ_lim_q + 10'h1; // see (RULE14)
        else if (keys_i.circ_dn && circ_lim_q != pts_pkg::CIRC_MIN)
            circ_lim_q <= circ_lim_q - 10'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            dly_q <= pts_pkg::DLY_RST;
        else if (keys_i.dly_up && dly_q != pts_pkg::DLY_MAX)
            dly_q <= dly_q + 7'h1; // see (RULE16)
        else if (keys_i.dly_dn && dly_q != pts_pkg::DLY_MIN)
            dly_q <= dly_q - 7'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            dev_q <= pts_pkg::DEV_RST;
        else if (keys_i.dev_up && dev_q != pts_pkg::DEV_MAX)
            dev_q <= dev_q + 3'h1; // see (RULE17)
        else if (keys_i.dev_dn && dev_q != pts_pkg::DEV_RST)
            dev_q <= dev_q - 3'h1;
    end

    pts_elect u_elect (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .peers_i    (peers_i),
        .groups_i   (groups),
        .self_i     (addr_o),
        .self_low_o (self_low),
        .any_peer_o (any_peer),
        .low_addr_o (low_addr)
    );

    // Address 0 keeps the node silent and out of coordination
    assign sync_mode = enable_i && addr_o != pts_pkg::ADDR_OFF
        && groups != 2'h0 && method_q != pts_pkg::PTS_CIRC; // see (RULE11)
    assign master = sync_mode && (method_q == pts_pkg::PTS_MASTER
        || (method_q == pts_pkg::PTS_AUTO && self_low)); // see (RULE1) (RULE5)
    // Follower without any sharing peer visible
    assign nomaster = sync_mode && !master && !any_peer; // see (RULE3)

    // Peers not yet registered simply do not take part
    genvar g;
    generate
        for (g = 0; g < pts_pkg::NODES; g++)
        begin : g_diff
            assign diff[g] = peers_i[g].tap > own_tap_i
                ? peers_i[g].tap - own_tap_i
                : own_tap_i - peers_i[g].tap; // see (RULE7)
        end
    endgenerate

    always_comb
    begin
        dev_fault = 1'b0;
        for (int i = 0; i < pts_pkg::NODES; i++)
            if (sync_mode && peers_i[i].present
                && (peers_i[i].groups & groups) != 2'h0
                && pts_pkg::TAP_W'(dev_q) < diff[i]
                && pts_pkg::ADDR_W'(i + 1) != addr_o
                && (master || pts_pkg::ADDR_W'(i + 1) == low_addr))
                dev_fault = 1'b1; // see (RULE6)
    end

    assign circ_fault = enable_i && groups != 2'h0
        && circ_pct_i > circ_lim_q; // see (RULE14)
    assign solo_block = standalone_block_i && enable_i
        && groups != 2'h0 && !any_peer; // see (RULE12)
    assign fault = dev_fault || circ_fault || nomaster;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cmd_raise_o <= '0;
            cmd_lower_o <= '0;
        end
        else
            for (int i = 0; i < pts_pkg::NODES; i++)
            begin
                cmd_raise_o[i] <= master && peers_i[i].present
                    && (peers_i[i].groups & groups) != 2'h0
                    && peers_i[i].tap < own_tap_i; // see (RULE2)
                cmd_lower_o[i] <= master && peers_i[i].present
                    && (peers_i[i].groups & groups) != 2'h0
                    && peers_i[i].tap > own_tap_i; // see (RULE2)
            end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            tap_cmd_o <= pts_pkg::PTS_CMD_NONE;
        else if (block_o)
            tap_cmd_o <= pts_pkg::PTS_CMD_NONE;
        else if (sync_mode && !master && !nomaster)
            tap_cmd_o <= rx_cmd_valid_i ? rx_cmd_i
                : pts_pkg::PTS_CMD_NONE; // see (RULE4)
        else
            tap_cmd_o <= own_cmd_i; // see (RULE1)
    end

    // Per mille of sensitivity times per mille of current
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            correction_o <= '0;
        else if (enable_i && method_q == pts_pkg::PTS_CIRC)
            correction_o <= 20'(sens_q) * 20'(circ_pct_i); // see (RULE13)
        else
            correction_o <= '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            block_o <= 1'b0;
        else
            block_o <= dev_fault || circ_fault || solo_block
                || (nomaster && nomaster_block_i); // see (RULE3) (RULE6)
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            nomaster_fault_o <= 1'b0;
            fault_lamp_o     <= 1'b0;
        end
        else
        begin
            nomaster_fault_o <= nomaster; // see (RULE3)
            fault_lamp_o     <= fault; // see (RULE16)
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            method_o <= pts_pkg::PTS_CIRC;
        else
            method_o <= method_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            groups_o <= 2'h0;
        else
            groups_o <= groups;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            bus_enable_o <= 1'b0;
        else
            bus_enable_o <= addr_o != pts_pkg::ADDR_OFF; // see (RULE11)
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            is_master_o <= 1'b0;
        else
            is_master_o <= master;
    end

    pts_fault_delay #(
        .TICK_CYC (TICK_CYC)
    ) u_delay (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .fault_i   (fault),
        .delay_s_i (dly_q),
        .out_o     (parallel_fault_output_o)
    );
endmodule : pts_parallel_ctrl

// ===== pts_parallel_ctrl_assertions.sv
`timescale 1ns/10ps
module pts_parallel_ctrl_assertions #(
    parameter int TICK_CYC = 10
) (
    input wire logic                         clk_i,
    input wire logic                         reset_i,
    input wire pts_pkg::pts_keys_t           keys_i,
    input wire logic                         grp_in_assigned_i,
    input wire logic [1:0]                   general_purpose_input_i,
    input wire pts_pkg::pts_method_t         method_o,
    input wire logic [1:0]                   groups_o,
    input wire logic [pts_pkg::ADDR_W-1:0]   addr_o,
    input wire logic                         bus_enable_o,
    input wire logic                         is_master_o,
    input wire logic [pts_pkg::NODES-1:0]    cmd_raise_o,
    input wire logic [pts_pkg::NODES-1:0]    cmd_lower_o,
    input wire logic                         fault_lamp_o,
    input wire logic                         parallel_fault_output_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // Cycles the lamp has been lit without a break
    logic [10:0] lamp_run_q;
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !fault_lamp_o)
            lamp_run_q <= 11'h000;
        else if (lamp_run_q != 11'h7ff)
            lamp_run_q <= lamp_run_q + 11'h001;
    end

    property p_step;
        logic [1:0] m;
        (keys_i.method_up, m = method_o) ##1 (keys_i == '0)[*2]
            |-> method_o == m + 2'h1;
    endproperty

    a_addr_range: assert property (addr_o <= pts_pkg::ADDR_MAX)
        else $error("address above range");
    a_bus_off: assert property ((addr_o == 5'h00)[*3] |-> !bus_enable_o)
        else $error("bus active at address zero");
    a_bus_on: assert property ((addr_o != 5'h00)[*3] |-> bus_enable_o)
        else $error("bus idle with valid address");
    a_method_step: assert property (p_step)
        else $error("method did not step up");
    a_cmd_excl: assert property ((cmd_raise_o & cmd_lower_o) == '0)
        else $error("raise and lower together");
    a_slave_quiet: assert property (!is_master_o[*3]
        |-> cmd_raise_o == '0 && cmd_lower_o == '0)
        else $error("commands from non-master");
    a_follow_role: assert property
        ((method_o == pts_pkg::PTS_FOLLOWER)[*3] |-> !is_master_o)
        else $error("follower acts as master");
    a_group_pin: assert property
        ((grp_in_assigned_i && $stable(general_purpose_input_i))[*5]
        |-> groups_o == general_purpose_input_i)
        else $error("group not taken from input");
    a_out_delay: assert property ($rose(parallel_fault_output_o)
        |-> lamp_run_q >= 11'(TICK_CYC))
        else $error("fault output too early");
    a_out_clear: assert property (parallel_fault_output_o |-> fault_lamp_o)
        else $error("fault output without fault");

    cover property ($rose(parallel_fault_output_o));
    cover property ($rose(is_master_o));
    cover property ($fell(bus_enable_o));
endmodule : pts_parallel_ctrl_assertions

// ===== pts_peer_model.sv
`timescale 1ns/10ps
module pts_peer_model (
    input  wire logic                                   clk_i,
    input  wire logic [15:0]                            present_i,
    input  wire logic [1:0]                             groups_i,
    input  wire logic [pts_pkg::TAP_W-1:0]              tap_i,
    input  wire pts_pkg::pts_cmd_t                      cmd_i,
    input  wire logic                                   cmd_valid_i,
    output pts_pkg::pts_peer_t [pts_pkg::NODES-1:0]     peers_o,
    output pts_pkg::pts_cmd_t                           rx_cmd_o,
    output logic                                        rx_cmd_valid_o
);
    logic [5:0] junk_q = 6'h15;
    // Absent peers churn, so stale data is never mistaken for valid
    always @(posedge clk_i)
    begin
        junk_q <= ~junk_q;
        rx_cmd_valid_o <= cmd_valid_i;
        rx_cmd_o <= cmd_valid_i ? cmd_i : pts_pkg::pts_cmd_t'(junk_q[1:0]);
        for (int g = 0; g < pts_pkg::NODES; g++)
        begin
            // Slot index g is bus address g+1, so no two peers share one
            peers_o[g] <= present_i[g] ? {1'b1, groups_i, tap_i}
                                       : {1'b0, junk_q[1:0], junk_q};
        end
    end
endmodule : pts_peer_model

// ===== pts_parallel_ctrl_test.sv
`timescale 1ns/10ps
module pts_parallel_ctrl_test;
    localparam int TICK = 10;
    localparam pts_pkg::pts_keys_t K_MUP = 13'h1000;
    localparam pts_pkg::pts_keys_t K_MDN = 13'h0800;
    localparam pts_pkg::pts_keys_t K_GUP = 13'h0400;
    localparam pts_pkg::pts_keys_t K_AUP = 13'h0200;
    localparam pts_pkg::pts_keys_t K_ADN = 13'h0100;
    localparam pts_pkg::pts_keys_t K_SUP = 13'h0080;
    localparam pts_pkg::pts_keys_t K_VUP = 13'h0002;
    logic               clk_i = 1'b0;
    logic               reset_i = 1'b1;
    logic               enable_i = 1'b0;
    pts_pkg::pts_keys_t keys_i = '0;
    logic               grp_in_assigned_i = 1'b0;
    logic [1:0]         general_purpose_input_i = 2'h0;
    logic               standalone_block_i = 1'b0;
    logic               nomaster_block_i = 1'b0;
    logic [5:0]         own_tap_i = 6'h07;
    logic [15:0]        pres = 16'h0000;
    logic [1:0]         pgrp = 2'h1;
    logic [5:0]         ptap = 6'h07;
    pts_pkg::pts_cmd_t  pcmd = pts_pkg::PTS_CMD_RAISE;
    logic               pval = 1'b0;
    pts_pkg::pts_cmd_t  own_cmd_i = pts_pkg::PTS_CMD_LOWER;
    logic [9:0]         circ_pct_i = 10'h000;
    pts_pkg::pts_peer_t [15:0] peers_i;
    pts_pkg::pts_cmd_t  rx_cmd_i, tap_cmd_o;
    pts_pkg::pts_method_t method_o;
    logic               rx_cmd_valid_i, bus_enable_o, is_master_o, block_o;
    logic               nomaster_fault_o, fault_lamp_o, parallel_fault_output_o;
    logic [1:0]         groups_o;
    logic [4:0]         addr_o;
    logic [15:0]        cmd_raise_o, cmd_lower_o;
    logic [19:0]        correction_o;
    int                 num_errors = 0;
    int                 checked = 0;
    int                 n;

    pts_peer_model peer (.clk_i, .present_i(pres), .groups_i(pgrp),
        .tap_i(ptap), .cmd_i(pcmd), .cmd_valid_i(pval), .peers_o(peers_i),
        .rx_cmd_o(rx_cmd_i), .rx_cmd_valid_o(rx_cmd_valid_i));
    pts_parallel_ctrl #(.TICK_CYC(TICK)) uut (.clk_i, .reset_i, .enable_i,
        .keys_i, .grp_in_assigned_i, .general_purpose_input_i,
        .standalone_block_i, .nomaster_block_i, .own_tap_i, .peers_i,
        .rx_cmd_i, .rx_cmd_valid_i, .own_cmd_i, .circ_pct_i, .method_o,
        .groups_o, .addr_o, .bus_enable_o, .is_master_o, .cmd_raise_o,
        .cmd_lower_o, .tap_cmd_o, .correction_o, .block_o,
        .nomaster_fault_o, .fault_lamp_o, .parallel_fault_output_o);

    initial
        forever #5 clk_i = ~clk_i;

    task automatic wt(input int c);
        repeat (c) @(negedge clk_i);
    endtask : wt

    task automatic chk(input logic [19:0] got, exp, input string what);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %0h", $time, what, got);
        end
    endtask : chk

    task automatic press(input pts_pkg::pts_keys_t k, input int c);
        repeat (c)
        begin
            @(negedge clk_i) keys_i = k;
            @(negedge clk_i) keys_i = '0;
            wt(3);
        end
    endtask : press

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        summarize();
    end

    initial
    begin
        wt(8);
        reset_i = 1'b0;
        enable_i = 1'b1;
        wt(2);
        chk(method_o, 20'h0, "reset method");
        chk(correction_o, 20'h0, "reset correction");
        press(K_ADN, 1);
        chk(addr_o, 20'h0, "address floor");
        chk(bus_enable_o, 20'h0, "bus off");
        press(K_AUP, 17);
        chk(addr_o, 20'h10, "address ceiling");
        chk(bus_enable_o, 20'h1, "bus on");
        press(K_GUP, 1);
        chk(groups_o, 20'h1, "group key");
        standalone_block_i = 1'b1;
        wt(4);
        chk(block_o, 20'h1, "alone blocked");
        pres = 16'h0002;
        wt(4);
        chk(block_o, 20'h0, "peer seen");
        standalone_block_i = 1'b0;
        $display("setup tests done");
        circ_pct_i = 10'h064;
        wt(3);
        chk(correction_o, 20'h0, "zero sensitivity");
        press(K_SUP, 5);
        chk(correction_o, 20'h1f4, "correction");
        circ_pct_i = 10'h0c8;
        wt(4);
        chk(fault_lamp_o, 20'h0, "at limit");
        circ_pct_i = 10'h0c9;
        wt(3);
        chk(fault_lamp_o, 20'h1, "lamp");
        chk(block_o, 20'h1, "circ block");
        wt(277);
        chk(parallel_fault_output_o, 20'h0, "early output");
        n = 0;
        while (parallel_fault_output_o !== 1'b1 && n < 40)
        begin
            wt(1);
            n++;
        end
        chk(parallel_fault_output_o, 20'h1, "delayed output");
        circ_pct_i = 10'h064;
        wt(3);
        chk(parallel_fault_output_o, 20'h0, "output cleared");
        circ_pct_i = 10'h191;
        wt(200);
        circ_pct_i = 10'h064;
        wt(2);
        circ_pct_i = 10'h191;
        wt(280);
        chk(parallel_fault_output_o, 20'h0, "count restarted");
        circ_pct_i = 10'h000;
        wt(3);
        $display("circulating current tests done");
        press(K_MUP, 1);
        chk(method_o, 20'h1, "master method");
        ptap = 6'h05;
        wt(4);
        chk(is_master_o, 20'h1, "is master");
        chk({cmd_raise_o[1], cmd_lower_o[1]}, 20'h2, "raise");
        ptap = 6'h09;
        wt(4);
        chk({cmd_raise_o[1], cmd_lower_o[1]}, 20'h1, "lower");
        press(K_MUP, 1);
        ptap = 6'h07;
        pval = 1'b1;
        wt(4);
        chk(is_master_o, 20'h0, "follower role");
        chk(tap_cmd_o, 20'h1, "follows command");
        ptap = 6'h08;
        wt(4);
        chk({fault_lamp_o, block_o}, 20'h3, "deviation");
        press(K_VUP, 1);
        chk(fault_lamp_o, 20'h0, "deviation allowed");
        pres = 16'h0000;
        pval = 1'b0;
        nomaster_block_i = 1'b1;
        wt(4);
        chk({nomaster_fault_o, block_o}, 20'h3, "no master");
        nomaster_block_i = 1'b0;
        wt(4);
        chk(block_o, 20'h0, "runs alone");
        chk(tap_cmd_o, 20'h2, "own command");
        press(K_MUP, 1);
        chk(method_o, 20'h3, "auto method");
        pres = 16'h0002;
        ptap = 6'h07;
        wt(4);
        chk(is_master_o, 20'h0, "lower peer wins");
        pgrp = 2'h2;
        wt(4);
        chk(is_master_o, 20'h1, "other group");
        press(K_MUP, 1);
        chk(method_o, 20'h0, "method wraps");
        press(K_MDN, 1);
        chk(method_o, 20'h3, "method down");
        $display("sync tests done");
        grp_in_assigned_i = 1'b1;
        general_purpose_input_i = 2'h2;
        wt(5);
        chk(groups_o, 20'h2, "group by input");
        press(K_GUP, 1);
        grp_in_assigned_i = 1'b0;
        wt(5);
        chk(groups_o, 20'h1, "key refused");
        press(K_ADN, 16);
        chk({addr_o, bus_enable_o}, 20'h0, "address zero");
        $display("group and address tests done");
        summarize();
    end
endmodule : pts_parallel_ctrl_test

bind pts_parallel_ctrl pts_parallel_ctrl_assertions #(.TICK_CYC(TICK_CYC))
    u_chk (.clk_i, .reset_i, .keys_i, .grp_in_assigned_i,
    .general_purpose_input_i, .method_o, .groups_o, .addr_o, .bus_enable_o,
    .is_master_o, .cmd_raise_o, .cmd_lower_o, .fault_lamp_o,
    .parallel_fault_output_o);
